// ===== hw/irq_timing_pkg.sv
// Purpose: shared constants and types for the interrupt entry timing block
// Assumes: one core clock per CLK cycle, all counts for cache hits
// Notes:   counts are in core clocks; penalties are added by the sequencer
package irq_timing_pkg;

  localparam int CNT_W = 12;

  typedef logic [CNT_W-1:0] count_t;

  typedef enum logic [2:0] {
    OP_SWINT,
    OP_BREAKPOINT,
    OP_OVERFLOW_TRAP,
    OP_RANGE_CHECK,
    OP_INTERRUPT_RETURN,
    OP_EXT_INT,
    OP_NMI,
    OP_PAGE_FAULT
  } op_e;

  typedef enum logic [1:0] {
    MODE_REAL,
    MODE_PROTECTED,
    MODE_VIRTUAL,
    MODE_RESERVED
  } mode_e;

  typedef enum logic [1:0] {
    GATE_SAME_LEVEL,
    GATE_DIFF_LEVEL,
    GATE_TASK,
    GATE_RESERVED
  } gate_e;

  typedef enum logic [1:0] {
    TSS_32BIT,
    TSS_16BIT,
    TSS_VIRTUAL,
    TSS_RESERVED
  } tss_e;

  // entry overhead
  localparam count_t ENTRY_REAL      = 12'h01A;  // 26
  localparam count_t ENTRY_PROT_SAME = 12'h02C;  // 44
  localparam count_t ENTRY_PROT_DIFF = 12'h047;  // 71
  localparam count_t ENTRY_VIRT_DIFF = 12'h052;  // 82
  localparam count_t ENTRY_TASK_GATE = 12'h025;  // 37

  // task switch overhead by target segment
  localparam count_t SWITCH_32BIT    = 12'h0A2;  // 162
  localparam count_t SWITCH_16BIT    = 12'h08F;  // 143
  localparam count_t SWITCH_VIRTUAL  = 12'h08C;  // 140

  // per-operation extras and standalone costs
  localparam count_t SWINT_EXTRA_RV  = 12'h004;
  localparam count_t SWINT_EXTRA_P   = 12'h000;
  localparam count_t BKPT_EXTRA      = 12'h000;
  localparam count_t OVF_TAKEN_EXTRA = 12'h002;
  localparam count_t OVF_NOT_TAKEN   = 12'h003;
  localparam count_t RANGE_IN        = 12'h007;
  localparam count_t RANGE_OUT_EXTRA = 12'h018;  // 24
  localparam count_t RET_REAL_VIRT   = 12'h00F;  // 15
  localparam count_t RET_SAME        = 12'h014;  // 20
  localparam count_t RET_OUTER       = 12'h024;  // 36
  localparam count_t RET_NESTED_EXTRA = 12'h020; // 32
  localparam count_t EXT_INT_EXTRA   = 12'h00B;  // 11
  localparam count_t NMI_EXTRA       = 12'h003;
  localparam count_t PF_EXTRA        = 12'h018;  // 24

  // penalties
  localparam count_t DESC_PENALTY    = 12'h00B;  // 11 per descriptor
  localparam count_t COPY_MISS_PEN   = 12'h006;  // per 16 bytes
  localparam count_t EXTRA_MISS_PEN  = 12'h004;  // per 16 bytes

  // vectors raised by fixed traps
  localparam logic [7:0] VEC_BREAKPOINT = 8'h03;
  localparam logic [7:0] VEC_OVERFLOW   = 8'h04;
  localparam logic [7:0] VEC_RANGE      = 8'h05;

endpackage

// ===== hw/cycle_timer.sv
// Purpose: down-counter that holds busy for a loaded number of clocks
// Assumes: load only while idle, value at least one
// Notes:   done is a one-cycle pulse raised on the same edge that busy falls
`timescale 1ns/100ps
`default_nettype none
module cycle_timer
  import irq_timing_pkg::*;
(
  input  wire logic   clk,        // core clock
  input  wire logic   rst_n,      // synchronised reset
  input  wire logic   load,       // start pulse
  input  wire count_t load_value, // clocks to run
  output var  logic   busy,       // counting
  output var  logic   done        // end pulse
);
  count_t remaining;
  count_t next_remaining;
  logic   next_busy;
  logic   next_done;

  always_comb begin
    next_remaining = remaining;
    next_busy      = busy;
    next_done      = 1'b0;
    if (busy) begin
      if (remaining == '0) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end else begin
        next_remaining = remaining - 12'h001;
      end
    end else if (load) begin
      next_busy      = 1'b1;
      // busy covers the load cycle, so run for value minus one more
      next_remaining = (load_value == '0) ? '0 : load_value - 12'h001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      remaining <= '0;
      busy      <= 1'b0;
      done      <= 1'b0;
    end else begin
      remaining <= next_remaining;
      busy      <= next_busy;
      done      <= next_done;
    end
  end
endmodule
`default_nettype wire

// ===== hw/irq_entry_timing.sv
// Purpose: sequences interrupt, trap and return timing in core clocks
// Assumes: request inputs come from logic on CLK, START is one cycle
// Notes:   requests while busy are ignored except in the last BUSY cycle; outputs are registered
`timescale 1ns/100ps
`default_nettype none
module irq_entry_timing
  import irq_timing_pkg::*;
#(
  parameter int DESC_W  = 4,   // width of descriptor load count
  parameter int BLOCK_W = 8    // width of 16-byte block count
)(
  input  wire logic               CLK,           // core clock
  input  wire logic               RESET_N,       // async reset, low
  input  wire logic               START,         // request pulse
  input  wire logic [2:0]         OPERATION,     // op_e code
  input  wire logic [1:0]         MODE,          // mode_e code
  input  wire logic [1:0]         GATE,          // gate_e code
  input  wire logic [1:0]         TASK_STATE_SEGMENT, // tss_e target
  input  wire logic [7:0]         VECTOR_IN,     // vector for soft/ext
  input  wire logic               OVERFLOW,      // overflow flag
  input  wire logic               OUT_OF_RANGE,  // range check failed
  input  wire logic               OUTER_LEVEL,   // return to outer level
  input  wire logic               NESTED_TASK_FLAG, // nested task flag
  input  wire logic [DESC_W-1:0]  UNACCESSED_DESC,  // descriptor loads
  input  wire logic               CACHE_MISS,    // copy missed cache
  input  wire logic               EXTRA_PENALTY, // op has extra penalty
  input  wire logic               ALWAYS_LOCKED, // op runs locked
  input  wire logic [BLOCK_W-1:0] MISS_BLOCKS,   // 16-byte blocks moved
  output var  logic               BUSY,          // sequence running
  output var  logic               DONE,          // end pulse
  output var  logic               TRAPPED,       // op vectored
  output var  logic [7:0]         VECTOR,        // vector taken
  output var  logic               NO_HIT_CASE,   // bus-only timing
  output var  count_t             CYCLES         // total clocks
);

  // wider inputs could overflow the 12-bit total
  if (DESC_W < 1 || DESC_W > 4 ||
      BLOCK_W < 1 || BLOCK_W > 8) begin : g_bad_width
    $error("irq_entry_timing: widths exceed count range");
  end

  // reset release through two flops
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  function automatic count_t switch_cost(input logic [1:0] task_state_segment);
    case (task_state_segment)
      TSS_32BIT:   switch_cost = SWITCH_32BIT;
      TSS_16BIT:   switch_cost = SWITCH_16BIT;
      TSS_VIRTUAL: switch_cost = SWITCH_VIRTUAL;
      default:     switch_cost = SWITCH_32BIT;
    endcase
  endfunction

  function automatic count_t entry_cost(input logic [1:0] mode,
                                        input logic [1:0] gate,
                                        input logic [1:0] task_state_segment);
    if (mode == MODE_REAL)
      entry_cost = ENTRY_REAL;
    else if (gate == GATE_TASK)
      entry_cost = ENTRY_TASK_GATE + switch_cost(task_state_segment);
    else if (mode == MODE_VIRTUAL)
      // only level-changing gates exist from virtual mode
      entry_cost = ENTRY_VIRT_DIFF;
    else if (gate == GATE_DIFF_LEVEL)
      entry_cost = ENTRY_PROT_DIFF;
    else
      entry_cost = ENTRY_PROT_SAME;
  endfunction

  // base cost, trap outcome and vector per operation
  count_t     base;
  count_t     entry;
  count_t     desc_pen;
  count_t     miss_pen;
  count_t     total;
  logic       trap;
  logic [7:0] vec;
  logic       miss;

  always_comb begin
    entry = entry_cost(MODE, GATE, TASK_STATE_SEGMENT);
    base  = entry;
    trap  = 1'b1;
    vec   = VECTOR_IN;
    case (op_e'(OPERATION))
      OP_SWINT:
        base = entry + ((MODE == MODE_PROTECTED) ?
               SWINT_EXTRA_P : SWINT_EXTRA_RV);
      OP_BREAKPOINT: begin
        base = entry + BKPT_EXTRA;
        vec  = VEC_BREAKPOINT;
      end
      OP_OVERFLOW_TRAP: begin
        vec = VEC_OVERFLOW;
        if (OVERFLOW) begin
          base = entry + OVF_TAKEN_EXTRA;
        end else begin
          base = OVF_NOT_TAKEN;
          trap = 1'b0;
        end
      end
      OP_RANGE_CHECK: begin
        vec = VEC_RANGE;
        if (OUT_OF_RANGE) begin
          base = entry + RANGE_OUT_EXTRA;
        end else begin
          base = RANGE_IN;
          trap = 1'b0;
        end
      end
      OP_INTERRUPT_RETURN: begin
        trap = 1'b0;
        if (NESTED_TASK_FLAG)
          base = switch_cost(TASK_STATE_SEGMENT) + RET_NESTED_EXTRA;
        else if (MODE != MODE_PROTECTED)
          base = RET_REAL_VIRT;
        else if (OUTER_LEVEL)
          base = RET_OUTER;
        else
          base = RET_SAME;
      end
      OP_EXT_INT:    base = entry + EXT_INT_EXTRA;
      OP_NMI:        base = entry + NMI_EXTRA;
      OP_PAGE_FAULT: base = entry + PF_EXTRA;
      default:       base = entry;
    endcase
  end

  // locked operations always reach the bus, so they always pay the miss
  assign miss = CACHE_MISS | ALWAYS_LOCKED;

  always_comb begin
    desc_pen = count_t'(DESC_PENALTY * UNACCESSED_DESC);
    miss_pen = '0;
    if (miss) begin
      miss_pen = count_t'(COPY_MISS_PEN * MISS_BLOCKS);
      if (EXTRA_PENALTY)
        miss_pen = miss_pen +
                   count_t'(EXTRA_MISS_PEN * MISS_BLOCKS);
    end
    // one core clock per CLK cycle, hit timing unless penalised
    total = base + desc_pen + miss_pen;
  end

  logic accept;
  logic timer_busy;
  logic timer_done;

  assign accept = START & ~timer_busy;

  cycle_timer u_timer (
    .clk        (CLK),
    .rst_n      (rst_n),
    .load       (accept),
    .load_value (total),
    .busy       (timer_busy),
    .done       (timer_done)
  );

  // result registers, held until the next accepted request
  logic       next_trapped;
  logic [7:0] next_vector;
  logic       next_no_hit;
  count_t     next_cycles;

  always_comb begin
    next_trapped = TRAPPED;
    next_vector  = VECTOR;
    next_no_hit  = NO_HIT_CASE;
    next_cycles  = CYCLES;
    if (accept) begin
      next_trapped = trap;
      next_vector  = trap ? vec : 8'h00;
      next_no_hit  = ALWAYS_LOCKED;
      next_cycles  = total;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      TRAPPED     <= 1'b0;
      VECTOR      <= 8'h00;
      NO_HIT_CASE <= 1'b0;
      CYCLES      <= '0;
      BUSY        <= 1'b0;
      DONE        <= 1'b0;
    end else begin
      TRAPPED     <= next_trapped;
      VECTOR      <= next_vector;
      NO_HIT_CASE <= next_no_hit;
      CYCLES      <= next_cycles;
      BUSY        <= timer_busy;
      DONE        <= timer_done;
    end
  end

endmodule
`default_nettype wire

// ===== test/irq_entry_timing_sva.sv
// Purpose: port-level timing checks for irq_entry_timing
// Assumes: one request at a time, never in the last busy cycle
// Notes:   run follows an accepted request until its done pulse
`timescale 1ns/100ps
`default_nettype none
module irq_entry_timing_chk
  import irq_timing_pkg::*;
#(
  parameter int DESC_W  = 4,
  parameter int BLOCK_W = 8
)(
  input wire logic              CLK,              // clock
  input wire logic              RESET_N,          // reset
  input wire logic              START,            // request
  input wire logic [2:0]        OPERATION,        // op
  input wire logic [1:0]        MODE,             // mode
  input wire logic [1:0]        GATE,             // gate
  input wire logic              OVERFLOW,         // flag
  input wire logic              OUT_OF_RANGE,     // fail
  input wire logic              NESTED_TASK_FLAG, // nested
  input wire logic [DESC_W-1:0] UNACCESSED_DESC,  // loads
  input wire logic              CACHE_MISS,       // miss
  input wire logic              ALWAYS_LOCKED,    // locked
  input wire logic              BUSY,             // busy
  input wire logic              DONE,             // done
  input wire logic              TRAPPED,          // trapped
  input wire logic [7:0]        VECTOR,           // vector
  input wire logic              NO_HIT_CASE,      // no hit
  input wire count_t            CYCLES            // count
);
  logic   run;
  logic   next_run;
  count_t bcnt;
  count_t next_bcnt;
  logic   acc;
  logic   np;
  assign acc = START && !run;
  assign np  = UNACCESSED_DESC == '0 && !CACHE_MISS && !ALWAYS_LOCKED;
  always_comb begin
    next_run  = acc ? 1'b1 : (DONE ? 1'b0 : run);
    next_bcnt = BUSY ? bcnt + 12'h001 : 12'h000;
  end
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      run  <= 1'b0;
      bcnt <= 12'h000;
    end else begin
      run  <= next_run;
      bcnt <= next_bcnt;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  a_busy_start: assert property (acc |=> !BUSY ##1 BUSY)
    else $error("busy not raised two edges after accept");
  a_busy_length: assert property ($fell(BUSY) |-> bcnt == CYCLES)
    else $error("busy length differs from count");
  a_done_end: assert property ($fell(BUSY) |-> DONE)
    else $error("done missing after busy");
  a_done_pulse: assert property (DONE |=> !DONE)
    else $error("done longer than one cycle");
  a_nohit_copy: assert property (acc |=>
    NO_HIT_CASE == $past(ALWAYS_LOCKED))
    else $error("no hit flag wrong");
  a_bkpt_real: assert property (acc && OPERATION == 3'h1 &&
    MODE == 2'h0 && !CACHE_MISS && !ALWAYS_LOCKED |=> VECTOR == 8'h03 &&
    CYCLES == 12'h01A + 12'h00B * $past(UNACCESSED_DESC))
    else $error("breakpoint count wrong");
  a_ovf_clear: assert property (acc && OPERATION == 3'h2 &&
    !OVERFLOW && np |=> CYCLES == 12'h003 && !TRAPPED)
    else $error("overflow not taken wrong");
  a_range_in: assert property (acc && OPERATION == 3'h3 &&
    !OUT_OF_RANGE && np |=> CYCLES == 12'h007 && !TRAPPED)
    else $error("range in bounds wrong");
  a_ret_real: assert property (acc && OPERATION == 3'h4 &&
    MODE == 2'h0 && !NESTED_TASK_FLAG && np |=> CYCLES == 12'h00F)
    else $error("real return count wrong");
  c_fault: cover property (acc && OPERATION == 3'h7);
  c_task: cover property (acc && GATE == 2'h2 && MODE == 2'h1);
  c_locked: cover property (acc && ALWAYS_LOCKED);
endmodule
bind irq_entry_timing irq_entry_timing_chk #(.DESC_W(DESC_W),
  .BLOCK_W(BLOCK_W)) u_chk (.CLK, .RESET_N, .START, .OPERATION, .MODE,
  .GATE, .OVERFLOW, .OUT_OF_RANGE, .NESTED_TASK_FLAG, .UNACCESSED_DESC,
  .CACHE_MISS, .ALWAYS_LOCKED, .BUSY, .DONE, .TRAPPED, .VECTOR,
  .NO_HIT_CASE, .CYCLES);
`default_nettype wire

// ===== test/irq_entry_timing_test.sv
// Purpose: self-checking bench for irq_entry_timing
// Assumes: penalties off unless a scenario sets them
// Notes:   inputs change on the falling edge only
`timescale 1ns/100ps
`default_nettype none
module irq_entry_timing_test
  import irq_timing_pkg::*;
;
  logic       CLK, RESET_N, START, OVERFLOW, OUT_OF_RANGE, OUTER_LEVEL;
  logic       NESTED_TASK_FLAG, CACHE_MISS, EXTRA_PENALTY, ALWAYS_LOCKED;
  logic       BUSY, DONE, TRAPPED, NO_HIT_CASE;
  logic [2:0] OPERATION;
  logic [1:0] MODE, GATE, TASK_STATE_SEGMENT;
  logic [3:0] UNACCESSED_DESC;
  logic [7:0] VECTOR_IN, VECTOR, MISS_BLOCKS;
  count_t     CYCLES;
  int         err_count = 0;
  int         check_count = 0;

  irq_entry_timing DUT (.CLK, .RESET_N, .START, .OPERATION, .MODE, .GATE,
    .TASK_STATE_SEGMENT, .VECTOR_IN, .OVERFLOW, .OUT_OF_RANGE,
    .OUTER_LEVEL, .NESTED_TASK_FLAG, .UNACCESSED_DESC, .CACHE_MISS,
    .EXTRA_PENALTY, .ALWAYS_LOCKED, .MISS_BLOCKS, .BUSY, .DONE, .TRAPPED,
    .VECTOR, .NO_HIT_CASE, .CYCLES);

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [11:0] e, g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic setop(input logic [2:0] o, input logic [1:0] m, g);
    OPERATION = o;
    MODE = m;
    GATE = g;
  endtask

  // done lands n plus one edges after the accepting edge
  task automatic go(input count_t n);
    int k;
    START = 1'b1;
    @(negedge CLK);
    START = 1'b0;
    chk("cycles", n, CYCLES);
    k = 1;
    while (DONE !== 1'b1 && k < 5000) begin
      @(negedge CLK);
      k++;
    end
    if (k >= 5000) begin
      err_count++;
      print_verdict();
    end
    chk("done_time", n + 12'h002, 12'(k));
    @(negedge CLK);
    chk("done_pulse", 12'h000, {11'h000, DONE});
  endtask

  task automatic t_soft;
    setop(3'h0, 2'h0, 2'h0);
    go(12'h01E);
    chk("vector", 12'h021, {4'h0, VECTOR});
    setop(3'h0, 2'h1, 2'h0);
    go(12'h02C);
  endtask

  task automatic t_bkpt;
    setop(3'h1, 2'h0, 2'h1);
    go(12'h01A);
    chk("vector", 12'h003, {4'h0, VECTOR});
    chk("trapped", 12'h001, {11'h000, TRAPPED});
    setop(3'h1, 2'h1, 2'h0);
    go(12'h02C);
    setop(3'h1, 2'h1, 2'h1);
    go(12'h047);
    setop(3'h1, 2'h2, 2'h1);
    go(12'h052);
  endtask

  task automatic t_ovf_range;
    OVERFLOW = 1'b1;
    setop(3'h2, 2'h0, 2'h0);
    go(12'h01C);
    chk("vector", 12'h004, {4'h0, VECTOR});
    OVERFLOW = 1'b0;
    go(12'h003);
    chk("trapped", 12'h000, {11'h000, TRAPPED});
    chk("vector", 12'h000, {4'h0, VECTOR});
    setop(3'h3, 2'h0, 2'h0);
    go(12'h007);
    OUT_OF_RANGE = 1'b1;
    go(12'h032);
    chk("vector", 12'h005, {4'h0, VECTOR});
    OUT_OF_RANGE = 1'b0;
  endtask

  task automatic t_ret_hw;
    setop(3'h4, 2'h0, 2'h0);
    go(12'h00F);
    setop(3'h4, 2'h1, 2'h0);
    go(12'h014);
    OUTER_LEVEL = 1'b1;
    go(12'h024);
    OUTER_LEVEL = 1'b0;
    NESTED_TASK_FLAG = 1'b1;
    go(12'h0C2);
    NESTED_TASK_FLAG = 1'b0;
    setop(3'h5, 2'h0, 2'h0);
    go(12'h025);
    setop(3'h6, 2'h1, 2'h0);
    go(12'h02F);
    setop(3'h7, 2'h0, 2'h0);
    go(12'h032);
  endtask

  task automatic t_task;
    count_t ts [3] = '{12'h0C7, 12'h0B4, 12'h0B1};
    setop(3'h1, 2'h1, 2'h2);
    for (int i = 0; i < 3; i++) begin
      TASK_STATE_SEGMENT = 2'(i);
      go(ts[i]);
    end
  endtask

  task automatic t_pen;
    setop(3'h1, 2'h0, 2'h0);
    UNACCESSED_DESC = 4'h2;
    go(12'h030);
    CACHE_MISS = 1'b1;
    MISS_BLOCKS = 8'h03;
    go(12'h042);
    EXTRA_PENALTY = 1'b1;
    go(12'h04E);
    {UNACCESSED_DESC, CACHE_MISS, EXTRA_PENALTY} = '0;
    ALWAYS_LOCKED = 1'b1;
    MISS_BLOCKS = 8'h02;
    go(12'h026);
    chk("no_hit", 12'h001, {11'h000, NO_HIT_CASE});
    ALWAYS_LOCKED = 1'b0;
  endtask

  // reset in mid-sequence must clear BUSY and every result output and recover cleanly
  task automatic t_reset;
    setop(3'h1, 2'h1, 2'h2);
    ALWAYS_LOCKED = 1'b1;
    START = 1'b1;
    @(negedge CLK);
    START = 1'b0;
    repeat (3) @(negedge CLK);
    chk("busy_run", 12'h001, {11'h000, BUSY});
    RESET_N = 1'b0;
    ALWAYS_LOCKED = 1'b0;
    @(negedge CLK);
    chk("busy_rst", 12'h000, {11'h000, BUSY});
    chk("cycles_rst", 12'h000, CYCLES);
    chk("trapped_rst", 12'h000, {11'h000, TRAPPED});
    chk("vector_rst", 12'h000, {4'h0, VECTOR});
    chk("no_hit_rst", 12'h000, {11'h000, NO_HIT_CASE});
    RESET_N = 1'b1;
    repeat (4) @(negedge CLK);
    go(12'h0B1);
  endtask

  initial begin
    {START, OVERFLOW, OUT_OF_RANGE, OUTER_LEVEL, NESTED_TASK_FLAG} = '0;
    {CACHE_MISS, EXTRA_PENALTY, ALWAYS_LOCKED, RESET_N} = '0;
    {OPERATION, MODE, GATE, TASK_STATE_SEGMENT} = '0;
    {UNACCESSED_DESC, MISS_BLOCKS} = '0;
    VECTOR_IN = 8'h21;
    repeat (2) @(negedge CLK);
    RESET_N = 1'b1;
    repeat (4) @(negedge CLK);
    t_soft();
    t_bkpt();
    t_ovf_range();
    t_ret_hw();
    t_task();
    t_pen();
    t_reset();
    print_verdict();
  end
endmodule
`default_nettype wire
